// file: swc_checker_properties.sv
// Concurrent checks of halt entry, wake-up and bus response at the controller ports
`timescale 1ns/100ps
module swc_checker (
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic                         halt_op,
  input wire logic [swc_pkg::NUM_WAKE-1:0] irq_flags,
  input wire logic [swc_pkg::NUM_WAKE-1:0] irq_enables,
  input wire logic                         clocked_irq_pending,
  input wire swc_pkg::swc_core_ctl_t       core_ctl,
  input wire logic                         power_down_flag,
  input wire logic                         timeout_flag,
  input wire logic                         osc_drive_en,
  input wire logic                         io_hold,
  input wire logic                         reset_pin_oe,
  input wire logic                         hreadyout,
  input wire logic                         hresp
);
  import swc_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Halted with oscillator off, and the same with an enabled wake flag
  sequence s_asleep; io_hold && !osc_drive_en; endsequence
  sequence s_asleep_req; io_hold && !osc_drive_en && |(irq_flags & irq_enables); endsequence
  property p_pin_bus; reset_pin_oe == 1'b0 && hreadyout && hresp == HRESP_OKAY; endproperty
  property p_entry; $rose(io_hold) |-> !power_down_flag && timeout_flag && !osc_drive_en && core_ctl.prefetch_next;
  endproperty
  property p_entry_cause; $rose(io_hold) |-> $past(halt_op); endproperty
  property p_leave; $fell(io_hold) |-> core_ctl.core_resume || core_ctl.core_reset || $past(core_ctl.core_reset);
  endproperty
  property p_irq_wake; s_asleep_req [*2] |-> ##[0:4] osc_drive_en; endproperty
  property p_vector; core_ctl.vector_branch |-> core_ctl.core_resume; endproperty
  property p_pulse; core_ctl.core_resume |=> !core_ctl.core_resume; endproperty
  property p_noop; halt_op && osc_drive_en && !io_hold && clocked_irq_pending
    |=> !io_hold && $stable(power_down_flag) && $stable(timeout_flag); endproperty
  property p_resume_osc; core_ctl.core_resume |-> osc_drive_en && $past(osc_drive_en); endproperty
  property p_hold_flags; s_asleep ##1 s_asleep |-> $stable(power_down_flag); endproperty
  a_pin_bus: assert property (p_pin_bus) else $error("reset pin driven or bus not ready");
  a_entry: assert property (p_entry) else $error("halt entry outputs wrong");
  a_entry_cause: assert property (p_entry_cause) else $error("hold without halt");
  a_leave: assert property (p_leave) else $error("left halt without command");
  a_irq_wake: assert property (p_irq_wake) else $error("enabled flag did not wake");
  a_vector: assert property (p_vector) else $error("vector without resume");
  a_pulse: assert property (p_pulse) else $error("resume not a pulse");
  a_noop: assert property (p_noop) else $error("halt not a no-op");
  a_resume_osc: assert property (p_resume_osc) else $error("resume before oscillator");
  a_hold_flags: assert property (p_hold_flags) else $error("flag moved while halted");
endmodule

bind swc_sleep_wakeup_control swc_checker chk_u (.hclk, .hresetn, .halt_op, .irq_flags, .irq_enables,
  .clocked_irq_pending, .core_ctl, .power_down_flag, .timeout_flag, .osc_drive_en, .io_hold, .reset_pin_oe,
  .hreadyout, .hresp);

// file: swc_core_model.sv
// Core model: halt and watchdog-clear pulses, free watchdog time base
`timescale 1ns/100ps
module swc_core_model (
  input  wire logic                   hclk,
  input  wire swc_pkg::swc_core_ctl_t core_ctl,
  output logic                        halt_op,
  output logic                        watchdog_clear_op,
  output logic                        wdt_tick
);
  import swc_pkg::*;
  int n_prefetch;
  // Time base runs free, unrelated to the clock
  initial begin
    halt_op = 1'b0;
    watchdog_clear_op = 1'b0;
    wdt_tick = 1'b0;
    n_prefetch = 0;
    forever #85 wdt_tick = ~wdt_tick;
  end
  // Count prefetches of completed halts
  always @(posedge hclk) if (core_ctl.prefetch_next === 1'b1) n_prefetch++;
  // One instruction for one cycle
  task automatic op(input logic clr);
    @(posedge hclk);
    halt_op <= ~clr;
    watchdog_clear_op <= clr;
    @(posedge hclk);
    halt_op <= 1'b0;
    watchdog_clear_op <= 1'b0;
  endtask
endmodule

// file: swc_pkg.sv
// Package for the sleep and wake-up controller: register map, fields, states and carriers
// How it works
// - Halt clears watchdog, watchdog keeps counting
// - Halt clears power-down flag, sets timeout flag
// - Halt switches the oscillator driver off
// - Pins hold their drive state while halted
// - Watchdog reset never drives the reset pin
// - Wake on pin reset, watchdog or interrupt
// - Watchdog wake clears the timeout flag
// - Power-up sets the power-down flag
// - Only six listed peripheral sources can wake
// - Clocked peripherals cannot wake a halted device
// - Halt requests prefetch of the next instruction
// - Enabled source wakes regardless of global enable
// - Global enable picks resume or vector branch
// - Every wake-up clears the watchdog
// - Wake reset option forces core reset on wake
// - Pending enabled interrupt turns halt into no-op
// - Interrupt during halt completes halt, then wakes
// - Crystal wake holds watchdog cleared through start-up
package swc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_WDT_LIMIT  = 8'h08;
  localparam logic [7:0] OFF_WDT_COUNT  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_WDT_EN      = 0;
  localparam int CTRL_WAKE_RST_N  = 1;
  localparam int CTRL_XTAL        = 2;
  localparam int CTRL_W           = 3;
  localparam logic [2:0] CTRL_RESET = 3'h2;
  localparam int ST_PD            = 0;
  localparam int ST_TO            = 1;
  localparam int ST_HALTED        = 2;
  localparam int ST_FSM_LSB       = 3;
  localparam int EV_HALT          = 0;
  localparam int EV_WAKE          = 1;
  localparam int EV_WDT_RESET     = 2;
  localparam int EV_HALT_NOP      = 3;
  localparam int EV_EXT_RESET     = 4;
  localparam int NUM_EV           = 5;

  // ****************************************************************
  // Wake sources, watchdog and start-up counts
  // ****************************************************************
  localparam int WS_TIMER_ONE     = 0;
  localparam int WS_SPECIAL_EVENT = 1;
  localparam int WS_NV_WRITE_DONE = 2;
  localparam int WS_COMPARATOR    = 3;
  localparam int WS_PIN_CHANGE    = 4;
  localparam int WS_EXT_IRQ       = 5;
  localparam int NUM_WAKE         = 6;
  localparam int WDT_W            = 16;
  localparam logic [15:0] WDT_LIMIT_RESET = 16'h00FF;
  localparam int OST_CYCLES       = 1024;
  localparam int OST_W            = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // States, Gray along run, halt, start-up, resume
  typedef enum logic [1:0] {
    SWC_RUN    = 2'h0,
    SWC_HALT   = 2'h1,
    SWC_OST    = 2'h3,
    SWC_RESUME = 2'h2
  } swc_fsm_t;

  // Commands to the core, one-cycle pulses except core_reset, held while the reset pin is low
  typedef struct packed {
    logic core_reset;
    logic core_resume;
    logic vector_branch;
    logic prefetch_next;
  } swc_core_ctl_t;

  // Whole state of the controller
  typedef struct packed {
    swc_fsm_t              fsm;
    logic [2:0]            pin_sy;
    logic                  pin_filt;
    logic [2:0]            tick_sy;
    logic                  tick_filt;
    logic [NUM_WAKE-1:0]   fl_s1;
    logic [NUM_WAKE-1:0]   fl_s2;
    logic [NUM_WAKE-1:0]   fl_s3;
    logic [NUM_WAKE-1:0]   fl_filt;
    logic [WDT_W-1:0]      wdt_cnt;
    logic [WDT_W-1:0]      wdt_limit;
    logic [OST_W-1:0]      ost_cnt;
    logic                  power_down_flag;
    logic                  timeout_flag;
    logic [CTRL_W-1:0]     ctrl;
    logic [NUM_EV-1:0]     ev_stat;
    logic [NUM_EV-1:0]     ev_en;
    logic                  wake_by_irq;
    logic                  wake_gie;
    logic                  dp_wr;
    logic [7:0]            dp_addr;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  resp;
    logic                  irq;
    logic                  osc_drive_en;
    logic                  io_hold;
    logic                  reset_pin_oe;
    swc_core_ctl_t         core;
  } swc_regs_t;

endpackage

// file: swc_sleep_wakeup_control.sv
// Sleep and wake-up controller with watchdog, status flags and AHB-Lite registers
`timescale 1ns/100ps
module swc_sleep_wakeup_control #(
  parameter int                 OST_COUNT = swc_pkg::OST_CYCLES,
  parameter logic [15:0]        WDT_LIMIT = swc_pkg::WDT_LIMIT_RESET
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          halt_op,
  input  wire logic                          watchdog_clear_op,
  input  wire logic                          global_irq_enable,
  input  wire logic [swc_pkg::NUM_WAKE-1:0]  irq_flags,
  input  wire logic [swc_pkg::NUM_WAKE-1:0]  irq_enables,
  input  wire logic                          clocked_irq_pending,
  input  wire logic                          external_reset_pin_n,
  input  wire logic                          wdt_tick,
  output swc_pkg::swc_core_ctl_t             core_ctl,
  output logic                               power_down_flag,
  output logic                               timeout_flag,
  output logic                               osc_drive_en,
  output logic                               io_hold,
  output logic                               reset_pin_oe,
  output logic                               irq
);
  import swc_pkg::*;

  swc_regs_t r;
  swc_regs_t n;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Whole controller in one combinational pass
  always_comb begin
    logic                 sel;
    logic                 tick_rise;
    logic                 wdt_en;
    logic                 wdt_expire;
    logic                 wake_pending;
    logic                 halt_blocked;
    logic                 do_wake;
    logic [NUM_EV-1:0]    ev_set;
    logic [NUM_EV-1:0]    ev_clr;
    sel          = 1'b0;
    tick_rise    = 1'b0;
    wdt_en       = 1'b0;
    wdt_expire   = 1'b0;
    wake_pending = 1'b0;
    halt_blocked = 1'b0;
    do_wake      = 1'b0;
    ev_set       = '0;
    ev_clr       = '0;
    n            = r;
    n.core       = '0;

    // Three-stage synchronisers; a change counts once stages two and three agree
    n.pin_sy  = {r.pin_sy[1:0], external_reset_pin_n};
    n.tick_sy = {r.tick_sy[1:0], wdt_tick};
    n.fl_s1   = irq_flags;
    n.fl_s2   = r.fl_s1;
    n.fl_s3   = r.fl_s2;
    if (r.pin_sy[1] == r.pin_sy[2]) begin
      n.pin_filt = r.pin_sy[1];
    end
    if (r.tick_sy[1] == r.tick_sy[2]) begin
      n.tick_filt = r.tick_sy[1];
    end
    n.fl_filt = (r.fl_s2 & r.fl_s3) | (r.fl_filt & (r.fl_s2 | r.fl_s3));
    tick_rise = (r.tick_sy[1] == r.tick_sy[2]) && r.tick_sy[1] && !r.tick_filt;

    // Wake sources: only the six listed flags, each gated by its own enable
    wake_pending = |(r.fl_filt & irq_enables);
    halt_blocked = wake_pending || clocked_irq_pending;

    // Watchdog counts its own time base, also while halted
    wdt_en     = r.ctrl[CTRL_WDT_EN];
    wdt_expire = wdt_en && tick_rise && (r.wdt_cnt == r.wdt_limit);
    if (!wdt_en) begin
      n.wdt_cnt = '0;
    end else if (tick_rise && r.fsm != SWC_OST) begin
      n.wdt_cnt = WDT_W'(r.wdt_cnt + 1'b1);
    end

    // Sequencer
    case (r.fsm)
      SWC_RUN: begin
        if (halt_op && halt_blocked) begin
          ev_set[EV_HALT_NOP] = 1'b1;
        end else if (halt_op) begin
          n.wdt_cnt         = '0;
          n.power_down_flag = 1'b0;
          n.timeout_flag    = 1'b1;
          n.core.prefetch_next = 1'b1;
          n.osc_drive_en    = 1'b0;
          n.io_hold         = 1'b1;
          n.fsm             = SWC_HALT;
          ev_set[EV_HALT]   = 1'b1;
        end else if (watchdog_clear_op) begin
          n.wdt_cnt         = '0;
          n.power_down_flag = 1'b1;
          n.timeout_flag    = 1'b1;
        end else if (wdt_expire) begin
          n.core.core_reset = 1'b1;
          n.timeout_flag    = 1'b0;
          n.wdt_cnt         = '0;
          ev_set[EV_WDT_RESET] = 1'b1;
        end
      end
      SWC_HALT: begin
        // Clocked peripherals are ignored here
        if (wake_pending) begin
          do_wake       = 1'b1;
          n.wake_by_irq = 1'b1;
        end else if (wdt_expire) begin
          do_wake        = 1'b1;
          n.wake_by_irq  = 1'b0;
          n.timeout_flag = 1'b0;
        end
        if (do_wake) begin
          n.wdt_cnt      = '0;
          n.wake_gie     = global_irq_enable;
          n.osc_drive_en = 1'b1;
          n.ost_cnt      = '0;
          n.fsm          = r.ctrl[CTRL_XTAL] ? SWC_OST : SWC_RESUME;
        end
      end
      SWC_OST: begin
        n.wdt_cnt = '0;
        n.ost_cnt = OST_W'(r.ost_cnt + 1'b1);
        if (r.ost_cnt == OST_W'(OST_COUNT - 1)) begin
          n.fsm = SWC_RESUME;
        end
      end
      SWC_RESUME: begin
        n.io_hold       = 1'b0;
        n.fsm           = SWC_RUN;
        ev_set[EV_WAKE] = 1'b1;
        if (!r.ctrl[CTRL_WAKE_RST_N]) begin
          n.core.core_reset = 1'b1;
        end else begin
          n.core.core_resume   = 1'b1;
          n.core.vector_branch = r.wake_by_irq && r.wake_gie;
        end
      end
      default: begin
        n.fsm = SWC_RUN;
      end
    endcase

    // External reset pin wins over the sequencer: core reset, run state, oscillator on, pins released, watchdog cleared
    if (!r.pin_filt) begin
      n.fsm             = SWC_RUN;
      n.core            = '0;
      n.core.core_reset = 1'b1;
      n.osc_drive_en    = 1'b1;
      n.io_hold         = 1'b0;
      n.wdt_cnt         = '0;
      ev_set[EV_EXT_RESET] = 1'b1;
    end
    n.reset_pin_oe = 1'b0;

    // AHB-Lite address phase
    sel       = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    n.dp_wr   = sel && hwrite;
    n.dp_addr = haddr[7:0];
    n.ready   = 1'b1;
    n.resp    = HRESP_OKAY;
    n.rdata   = '0;
    if (sel && !hwrite) begin
      case (haddr[7:0])
        OFF_CTRL:       n.rdata = {29'h0, r.ctrl};
        OFF_STATUS:     n.rdata = {27'h0, r.fsm, (r.fsm != SWC_RUN),
                                   r.timeout_flag, r.power_down_flag};
        OFF_WDT_LIMIT:  n.rdata = {16'h0, r.wdt_limit};
        OFF_WDT_COUNT:  n.rdata = {16'h0, r.wdt_cnt};
        OFF_IRQ_STATUS: n.rdata = {27'h0, r.ev_stat};
        OFF_IRQ_ENABLE: n.rdata = {27'h0, r.ev_en};
        default:        n.rdata = '0;
      endcase
    end

    // AHB-Lite data phase write
    if (r.dp_wr) begin
      case (r.dp_addr)
        OFF_CTRL:       n.ctrl      = hwdata[CTRL_W-1:0];
        OFF_WDT_LIMIT:  n.wdt_limit = hwdata[WDT_W-1:0];
        OFF_IRQ_CLEAR:  ev_clr      = hwdata[NUM_EV-1:0];
        OFF_IRQ_ENABLE: n.ev_en     = hwdata[NUM_EV-1:0];
        default:        n.ctrl      = r.ctrl;
      endcase
    end

    // Sticky events: a set in the clearing cycle wins
    n.ev_stat = (r.ev_stat & ~ev_clr) | ev_set;
    n.irq     = |(n.ev_stat & n.ev_en);
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Power-up values; flags set at power-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r                 <= '0;
      r.fsm             <= SWC_RUN;
      r.pin_sy          <= 3'h7;
      r.pin_filt        <= 1'b1;
      r.power_down_flag <= 1'b1;
      r.timeout_flag    <= 1'b1;
      r.ctrl            <= CTRL_RESET;
      r.wdt_limit       <= WDT_LIMIT;
      r.ready           <= 1'b1;
      r.osc_drive_en    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign hrdata          = r.rdata;
  assign hreadyout       = r.ready;
  assign hresp           = r.resp;
  assign core_ctl        = r.core;
  assign power_down_flag = r.power_down_flag;
  assign timeout_flag    = r.timeout_flag;
  assign osc_drive_en    = r.osc_drive_en;
  assign io_hold         = r.io_hold;
  assign reset_pin_oe    = r.reset_pin_oe;
  assign irq             = r.irq;

endmodule

// file: tb_sleep_wakeup_control.sv
// Testbench: register access, halt and wake sequences
`timescale 1ns/100ps
module tb_sleep_wakeup_control;
  import swc_pkg::*;
  logic                hclk, hresetn, hsel, hwrite, global_irq_enable, clocked_irq_pending;
  logic                external_reset_pin_n, halt_op, watchdog_clear_op, wdt_tick, hreadyout, hresp;
  logic                power_down_flag, timeout_flag, osc_drive_en, io_hold, reset_pin_oe, irq;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [NUM_WAKE-1:0] irq_flags, irq_enables;
  swc_core_ctl_t       core_ctl;
  int                  mismatches, samples_checked, lat, lat0;
  wire logic [4:0]     entry = {core_ctl.prefetch_next, io_hold, osc_drive_en, power_down_flag, timeout_flag};

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  swc_sleep_wakeup_control #(.OST_COUNT(4), .WDT_LIMIT(16'h0003)) dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .halt_op,
    .watchdog_clear_op, .global_irq_enable, .irq_flags, .irq_enables, .clocked_irq_pending,
    .external_reset_pin_n, .wdt_tick, .core_ctl, .power_down_flag, .timeout_flag, .osc_drive_en, .io_hold,
    .reset_pin_oe, .irq);
  swc_core_model core_u (.hclk, .core_ctl, .halt_op, .watchdog_clear_op, .wdt_tick);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // Single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e, "read");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge hclk);
    #1 chk(32'(irq), 32'(e), "irq");
  endtask

  // Bounded wait for resume or reset, then check the command bits
  task automatic wait_cmd(input logic [2:0] e);
    lat = 0;
    while (lat < 200 && (core_ctl.core_resume | core_ctl.core_reset) !== 1'b1) begin
      @(posedge hclk);
      #1 lat++;
    end
    chk(32'({core_ctl.core_reset, core_ctl.core_resume, core_ctl.vector_branch}), 32'(e), "wake");
  endtask

  // Halt, then raise one wake flag
  task automatic halt_wake(input int src, input logic g, input logic [2:0] e);
    core_u.op(1'b0);
    #1 chk(32'(entry), 32'h19, "entry");
    @(posedge hclk);
    irq_flags <= 6'h01 << src;
    global_irq_enable <= g;
    wait_cmd(e);
    irq_flags <= 6'h00;
    repeat (6) @(posedge hclk);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #150000;
    mismatches++;
    end_of_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwrite = 1'b0;
    hwdata = 32'h0;
    global_irq_enable = 1'b0;
    clocked_irq_pending = 1'b0;
    external_reset_pin_n = 1'b1;
    irq_flags = 6'h00;
    irq_enables = 6'h00;
    mismatches = 0;
    samples_checked = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(OFF_STATUS, 32'h3);
    rd(OFF_CTRL, 32'h2);
    rd(OFF_WDT_LIMIT, 32'h3);
    rd(8'h1C, 32'h0);
    wr(OFF_IRQ_ENABLE, 32'h1F);
    irq_enables <= 6'h3F;
    for (int i = 0; i < NUM_WAKE; i++) halt_wake(i, i[0], {2'b01, i[0]});
    lat0 = lat;
    // Disabled and clock-needing sources never wake; reset pin does
    irq_enables <= 6'h3E;
    core_u.op(1'b0);
    irq_flags <= 6'h01;
    clocked_irq_pending <= 1'b1;
    repeat (20) @(posedge hclk);
    #1 chk(32'(osc_drive_en), 32'h0, "asleep");
    external_reset_pin_n <= 1'b0;
    wait_cmd(3'b100);
    external_reset_pin_n <= 1'b1;
    irq_flags <= 6'h00;
    clocked_irq_pending <= 1'b0;
    irq_enables <= 6'h3F;
    repeat (6) @(posedge hclk);
    #1 chk(32'({power_down_flag, timeout_flag}), 32'h1, "flags kept");
    // No-op halt, then interrupt raise, mask and clear
    wr(OFF_IRQ_CLEAR, 32'h1F);
    clocked_irq_pending <= 1'b1;
    core_u.op(1'b1);
    core_u.op(1'b0);
    #1 chk(32'({io_hold, power_down_flag, timeout_flag}), 32'h3, "no-op");
    clocked_irq_pending <= 1'b0;
    rd(OFF_IRQ_STATUS, 32'h8);
    chk_irq(1'b1);
    wr(OFF_IRQ_ENABLE, 32'h0);
    chk_irq(1'b0);
    wr(OFF_IRQ_ENABLE, 32'h1F);
    chk_irq(1'b1);
    wr(OFF_IRQ_CLEAR, 32'h8);
    chk_irq(1'b0);
    wr(OFF_CTRL, 32'h0);
    halt_wake(5, 1'b1, 3'b100);
    wr(OFF_CTRL, 32'h6);
    halt_wake(3, 1'b0, 3'b010);
    chk(32'(lat >= lat0 + 4), 32'h1, "start-up");
    // Watchdog keeps counting while halted and wakes the core
    wr(OFF_CTRL, 32'h3);
    core_u.op(1'b0);
    wait_cmd(3'b010);
    chk(32'({power_down_flag, timeout_flag}), 32'h0, "watchdog wake");
    wr(OFF_CTRL, 32'h2);
    chk(32'(core_u.n_prefetch), 32'd10, "prefetches");
    end_of_test();
  end
endmodule
